// ---- rtl/fcwl_cfg.svh ----
// Purpose: constants for the flash configuration word loader
// Assumes: 24-bit flash words, byte-free word addressing as printed
// Notes:   part tops, base addresses, word step, field bits and counts live here
`ifndef FCWL_CFG_SVH
`define FCWL_CFG_SVH
`define FCWL_ADDR_W          24
`define FCWL_DATA_W          24
`define FCWL_NWORDS          4
`define FCWL_TOP_LARGE       24'h0157FE
`define FCWL_TOP_SMALL       24'h00ABFE
`define FCWL_WORD_STEP       24'h000002
`define FCWL_CFG_SPACE_BASE  24'hF80000
`define FCWL_CFG_SPACE_LO    24'h800000
`define FCWL_UPPER_ONES      8'hFF
`define FCWL_CW1_RSVD        15
`define FCWL_CW1_SCAN        14
`define FCWL_CW1_GCP         13
`define FCWL_CW1_GENERAL_WRITE_PROTECT        12
`define FCWL_CW1_DEBUG       11
`define FCWL_CW1_RETENTION_REGULATOR_CFG       10
`define FCWL_CW1_ICS_HI      9
`define FCWL_CW1_ICS_LO      8
`define FCWL_CW1_WDT_HI      7
`define FCWL_CW1_WDT_LO      6
`define FCWL_CW1_WINDOW_WATCHDOG_DISABLE      5
`define FCWL_CW1_PSA         4
`define FCWL_CW1_PS_HI       3
`define FCWL_CW2_INITIAL_OSCILLATOR_SELECT_HI    10
`define FCWL_CW2_INITIAL_OSCILLATOR_SELECT_LO    8
`define FCWL_CW2_CKSM_HI     7
`define FCWL_CW2_CKSM_LO     6
`define FCWL_CW2_POSC_HI     1
`define FCWL_READ_LAT        2
`endif

// ---- rtl/fcwl_pkg.sv ----
// Purpose: types for the flash configuration word loader
// Assumes: nothing beyond the cfg header
// Notes:   enum codes left to the tool
package fcwl_pkg;
    typedef enum logic [2:0] {
        FCWL_IDLE,
        FCWL_ISSUE,
        FCWL_WAIT,
        FCWL_DONE
    } fcwl_state_e;
    typedef logic [23:0] fcwl_word_t;
endpackage

// ---- rtl/fcwl_word_reg.sv ----
// Purpose: one volatile configuration word holding register
// Assumes: loaded only by the sequencer, erased value all ones
// Notes:   upper byte is never stored and always reads as ones
`timescale 1ns/100ps
`default_nettype none
`include "fcwl_cfg.svh"
module fcwl_word_reg (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    input  wire logic                 load_i,
    input  wire logic [23:0]          data_i,
    output var  logic [23:0]          word_o
);
    logic [15:0] low_reg;
    // reset to erased pattern; only low 16 bits exist
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            low_reg <= 16'hFFFF;
        end else if (ce_i && load_i) begin
            low_reg <= data_i[15:0]; // upper byte dropped
        end
    end
    assign word_o = {`FCWL_UPPER_ONES, low_reg};
endmodule
`default_nettype wire

// ---- rtl/fcwl_loader.sv ----
// Purpose: copy flash configuration words into volatile config registers
// Assumes: flash read port answers after a fixed read latency
// Notes:   device reset is held until every word has been latched
`timescale 1ns/100ps
`default_nettype none
`include "fcwl_cfg.svh"
module fcwl_loader
    import fcwl_pkg::*;
(
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic                  dev_reset_req_i,
    input  wire logic                  large_part_i,
    output var  logic [23:0]           flash_addr_o,
    output var  logic                  flash_rd_o,
    input  wire logic [23:0]           flash_data_i,
    input  wire logic                  tbl_rd_i,
    input  wire logic [23:0]           tbl_addr_i,
    output var  logic [23:0]           tbl_data_o,
    output var  logic                  dev_reset_o,
    output var  logic                  scan_port_enable_o,
    output var  logic                  general_code_protect_o,
    output var  logic                  general_write_protect_o,
    output var  logic                  debug_mode_o,
    output var  logic                  retention_regulator_cfg_o,
    output var  logic                  retention_allowed_o,
    output var  logic [1:0]            emulator_pin_pair_select_o,
    output var  logic                  emulator_pin_reserved_o,
    output var  logic                  watchdog_force_on_o,
    output var  logic                  watchdog_sw_ctl_o,
    output var  logic                  watchdog_run_only_o,
    output var  logic                  window_watchdog_disable_o,
    output var  logic                  window_cfg_error_o,
    output var  logic                  watchdog_prescale_select_o,
    output var  logic [3:0]            watchdog_postscale_select_o,
    output var  logic [2:0]            initial_oscillator_select_o,
    output var  logic [1:0]            primary_osc_config_o,
    output var  logic                  clock_switch_enable_o,
    output var  logic                  clock_monitor_enable_o
);
    import fcwl_pkg::*;

    fcwl_state_e      state_reg;
    logic [1:0]       idx_reg;
    logic [1:0]       lat_reg;
    wire logic [3:0]  load_vec;
    fcwl_word_t       word_arr [0:3];
    fcwl_word_t       top_addr;
    fcwl_word_t       cw1;
    fcwl_word_t       cw2;
    logic             start_req;

    assign start_req = rst_i | dev_reset_req_i;
    assign top_addr = large_part_i ? `FCWL_TOP_LARGE
                                   : `FCWL_TOP_SMALL;

    // load sequencer; any reset restarts the whole copy
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_reg <= FCWL_IDLE;
            idx_reg   <= 2'h0;
            lat_reg   <= 2'h0;
        end else if (ce_i) begin
            if (dev_reset_req_i) begin
                state_reg <= FCWL_ISSUE;
                idx_reg   <= 2'h0;
            end else begin
                case (state_reg)
                    FCWL_IDLE: begin
                        state_reg <= FCWL_ISSUE;
                        idx_reg   <= 2'h0;
                    end
                    FCWL_ISSUE: begin
                        state_reg <= FCWL_WAIT;
                        lat_reg   <= 2'(`FCWL_READ_LAT - 1);
                    end
                    FCWL_WAIT: begin
                        if (lat_reg == 2'h0) begin
                            if (idx_reg == 2'h3) begin
                                state_reg <= FCWL_DONE;
                            end else begin
                                state_reg <= FCWL_ISSUE;
                                idx_reg   <= idx_reg + 2'h1;
                            end
                        end else begin
                            lat_reg <= lat_reg - 2'h1;
                        end
                    end
                    default: begin
                        state_reg <= FCWL_DONE;
                    end
                endcase
            end
        end
    end

    // flash read request, addresses walk down from the top word
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            flash_rd_o   <= 1'b0;
            flash_addr_o <= 24'h000000;
        end else if (ce_i) begin
            flash_rd_o   <= (state_reg == FCWL_ISSUE) & ~dev_reset_req_i;
            flash_addr_o <= top_addr - 24'(idx_reg) * `FCWL_WORD_STEP;
        end
    end

    // device reset held until the last word is in place
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            dev_reset_o <= 1'b1;
        end else if (ce_i) begin
            dev_reset_o <= start_req | (state_reg != FCWL_DONE);
        end
    end

    // one holding register per configuration word
    genvar g;
    generate
        for (g = 0; g < `FCWL_NWORDS; g++) begin : g_word
            assign load_vec[g] = (state_reg == FCWL_WAIT) &&
                                 (lat_reg == 2'h0) &&
                                 (idx_reg == 2'(g)) && !dev_reset_req_i;
            fcwl_word_reg u_word (
                .mclk_i (mclk_i),
                .rst_i  (rst_i),
                .ce_i   (ce_i),
                .load_i (load_vec[g]),
                .data_i (flash_data_i),
                .word_o (word_arr[g])
            );
        end
    endgenerate

    assign cw1 = word_arr[0];
    assign cw2 = word_arr[1];

    // table read port: config space only, words at even steps
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tbl_data_o <= 24'h000000;
        end else if (ce_i && tbl_rd_i) begin
            if (tbl_addr_i == `FCWL_CFG_SPACE_BASE) begin
                tbl_data_o <= cw1;
            end else if (tbl_addr_i == `FCWL_CFG_SPACE_BASE + 24'h000002) begin
                tbl_data_o <= cw2;
            end else if (tbl_addr_i == `FCWL_CFG_SPACE_BASE + 24'h000004) begin
                tbl_data_o <= word_arr[2];
            end else if (tbl_addr_i == `FCWL_CFG_SPACE_BASE + 24'h000006) begin
                tbl_data_o <= word_arr[3];
            end else begin
                tbl_data_o <= 24'h000000;
            end
        end
    end

    // decoded word-one settings; only updated once loading finished
    // so dependent logic never sees a half-loaded pattern
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            scan_port_enable_o         <= 1'b1;
            general_code_protect_o     <= 1'b0;
            general_write_protect_o    <= 1'b0;
            debug_mode_o               <= 1'b0;
            retention_regulator_cfg_o  <= 1'b1;
            retention_allowed_o        <= 1'b0;
            emulator_pin_pair_select_o <= 2'h3;
            emulator_pin_reserved_o    <= 1'b0;
            watchdog_force_on_o        <= 1'b1;
            watchdog_sw_ctl_o          <= 1'b0;
            watchdog_run_only_o        <= 1'b0;
            window_watchdog_disable_o  <= 1'b1;
            window_cfg_error_o         <= 1'b0;
            watchdog_prescale_select_o <= 1'b1;
            watchdog_postscale_select_o <= 4'hF;
        end else if (ce_i && state_reg == FCWL_DONE && !start_req) begin
            scan_port_enable_o      <= cw1[`FCWL_CW1_SCAN];
            general_code_protect_o  <= ~cw1[`FCWL_CW1_GCP];
            general_write_protect_o <= ~cw1[`FCWL_CW1_GENERAL_WRITE_PROTECT];
            debug_mode_o            <= ~cw1[`FCWL_CW1_DEBUG];
            retention_regulator_cfg_o <= cw1[`FCWL_CW1_RETENTION_REGULATOR_CFG];
            retention_allowed_o     <= ~cw1[`FCWL_CW1_RETENTION_REGULATOR_CFG];
            emulator_pin_pair_select_o <=
                cw1[`FCWL_CW1_ICS_HI:`FCWL_CW1_ICS_LO];
            emulator_pin_reserved_o <=
                (cw1[`FCWL_CW1_ICS_HI:`FCWL_CW1_ICS_LO] == 2'h0);
            watchdog_force_on_o <=
                (cw1[`FCWL_CW1_WDT_HI:`FCWL_CW1_WDT_LO] == 2'h3);
            watchdog_sw_ctl_o <=
                (cw1[`FCWL_CW1_WDT_HI:`FCWL_CW1_WDT_LO] == 2'h2);
            watchdog_run_only_o <=
                (cw1[`FCWL_CW1_WDT_HI:`FCWL_CW1_WDT_LO] == 2'h1);
            window_watchdog_disable_o <= cw1[`FCWL_CW1_WINDOW_WATCHDOG_DISABLE];
            window_cfg_error_o <= ~cw1[`FCWL_CW1_WINDOW_WATCHDOG_DISABLE] &&
                (cw1[`FCWL_CW1_WDT_HI:`FCWL_CW1_WDT_LO] == 2'h0);
            watchdog_prescale_select_o <= cw1[`FCWL_CW1_PSA];
            watchdog_postscale_select_o <= cw1[`FCWL_CW1_PS_HI:0];
        end
    end

    // decoded word-two oscillator settings
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            initial_oscillator_select_o <= 3'h7;
            primary_osc_config_o        <= 2'h3;
            clock_switch_enable_o       <= 1'b0;
            clock_monitor_enable_o      <= 1'b0;
        end else if (ce_i && state_reg == FCWL_DONE && !start_req) begin
            initial_oscillator_select_o <=
                cw2[`FCWL_CW2_INITIAL_OSCILLATOR_SELECT_HI:`FCWL_CW2_INITIAL_OSCILLATOR_SELECT_LO];
            primary_osc_config_o <= cw2[`FCWL_CW2_POSC_HI:0];
            clock_switch_enable_o <= ~cw2[`FCWL_CW2_CKSM_HI];
            clock_monitor_enable_o <=
                (cw2[`FCWL_CW2_CKSM_HI:`FCWL_CW2_CKSM_LO] == 2'h0);
        end
    end

    // device reset must stay up while the sequencer is busy
    a_reset_held: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && $past(ce_i) && $past(state_reg) != FCWL_DONE
        |-> dev_reset_o)
        else $error("device reset released before load finished");
    // write protect follows the latched word-one bit
    a_wrp_follow: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && state_reg == FCWL_DONE && !start_req
        ##1 ce_i |-> general_write_protect_o == ~$past(cw1[12]))
        else $error("write protect mismatch");
    // code protect follows latched bit
    a_gcp_follow: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && state_reg == FCWL_DONE && !start_req
        ##1 ce_i |-> general_code_protect_o == ~$past(cw1[13]))
        else $error("code protect mismatch");
    // reset request restarts from word one on the next enabled cycle
    a_restart_load: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && dev_reset_req_i ##1 ce_i |-> state_reg == FCWL_ISSUE
        && idx_reg == 2'h0)
        else $error("reset request did not restart load");
    // upper byte of word one seen at the table port is ones; checked at the port
    // because the holding register ties it off by construction
    a_upper_ones: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && tbl_rd_i && tbl_addr_i == `FCWL_CFG_SPACE_BASE
        |=> tbl_data_o[23:16] == `FCWL_UPPER_ONES)
        else $error("upper byte not all ones");
    // windowed watchdog with code off is flagged
    a_window_err: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        window_cfg_error_o |-> !window_watchdog_disable_o
        && !watchdog_force_on_o && !watchdog_sw_ctl_o)
        else $error("window error flag inconsistent");
    // only one watchdog mode active at a time
    a_wdt_onehot: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        $onehot0({watchdog_force_on_o, watchdog_sw_ctl_o,
                  watchdog_run_only_o}))
        else $error("watchdog modes overlap");
    // regulator off and retention control are exclusive
    a_regulator: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        retention_regulator_cfg_o != retention_allowed_o)
        else $error("regulator decode inconsistent");
    // monitor only enabled with switching
    a_monitor_sw: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        clock_monitor_enable_o |-> clock_switch_enable_o)
        else $error("monitor on without clock switching");
    // read strobe is a single enabled cycle per word
    a_rd_pulse: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && flash_rd_o |=> !flash_rd_o)
        else $error("flash read strobe longer than one cycle");
    // config space outside the four words reads back as zero
    a_tbl_refuse: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ce_i && tbl_rd_i && tbl_addr_i == `FCWL_CFG_SPACE_LO
        |=> tbl_data_o == 24'h000000)
        else $error("table read outside config words not zero");
    // decodes stay put while a load is in flight
    a_decode_frozen: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        state_reg != FCWL_DONE |=> $stable({debug_mode_o,
            scan_port_enable_o, initial_oscillator_select_o}))
        else $error("decoded setting changed during load");
endmodule
`default_nettype wire

// ---- test/fcwl_flash_model.sv ----
// Purpose: program flash array model holding four configuration words
// Assumes: loader samples read data within three enabled cycles of strobe
// Notes:   outside that window the bus shows the inverse of the last word
`timescale 1ns/100ps
`default_nettype none
module fcwl_flash_model (
    input  wire logic        mclk_i,
    input  wire logic        ce_i,
    input  wire logic        large_part_i,
    input  wire logic        flash_rd_i,
    input  wire logic [23:0] flash_addr_i,
    input  wire logic [23:0] word1_i,
    input  wire logic [23:0] word2_i,
    input  wire logic [23:0] word3_i,
    input  wire logic [23:0] word4_i,
    output logic      [23:0] flash_data_o
);
    logic [23:0] top;
    logic [23:0] last = 24'h000000;
    logic [1:0]  hold = 2'h0;
    // configuration words sit in the four highest word slots
    assign top = large_part_i ? 24'h0157FE : 24'h00ABFE;
    // those slots hold configuration data only, never program code
    always @(posedge mclk_i) begin
        if (ce_i && flash_rd_i) begin
            hold <= 2'h3;
            case (top - flash_addr_i)
                24'h000000: last <= word1_i;
                24'h000002: last <= word2_i;
                24'h000004: last <= word3_i;
                24'h000006: last <= word4_i;
                default:    last <= 24'hC3C3C3; // ordinary code elsewhere
            endcase
        end else if (ce_i && hold != 2'h0) begin
            hold <= hold - 2'h1;
        end
    end
    // a stale word must not look valid, so the bus shows its inverse
    assign flash_data_o = (hold != 2'h0) ? last : ~last;
endmodule
`default_nettype wire

// ---- test/fcwl_loader_test.sv ----
// Purpose: self-checking bench for the configuration word loader
// Assumes: flash model answers inside the loader's read window
// Notes:   expected decodes are worked out here from the packed words
`timescale 1ns/100ps
`default_nettype none
module fcwl_loader_test;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic        dev_reset_req_i = 1'b0;
    logic        large_part_i = 1'b1;
    logic        tbl_rd_i = 1'b0;
    logic [23:0] tbl_addr_i = 24'h000000;
    logic [23:0] fw [4] = '{default: 24'h000000};
    wire  logic [23:0] flash_data_i;
    logic [23:0] flash_addr_o, tbl_data_o;
    logic [3:0]  watchdog_postscale_select_o;
    logic [2:0]  initial_oscillator_select_o;
    logic [1:0]  emulator_pin_pair_select_o, primary_osc_config_o;
    logic        flash_rd_o, dev_reset_o, scan_port_enable_o;
    logic        general_code_protect_o, general_write_protect_o;
    logic        debug_mode_o, retention_regulator_cfg_o;
    logic        retention_allowed_o, emulator_pin_reserved_o;
    logic        watchdog_force_on_o, watchdog_sw_ctl_o;
    logic        watchdog_run_only_o, window_watchdog_disable_o;
    logic        window_cfg_error_o, watchdog_prescale_select_o;
    logic        clock_switch_enable_o, clock_monitor_enable_o;
    logic        addr_chk = 1'b1;
    int          idx = 0;
    int          n_rd = 0;
    int          n_mismatch = 0;
    int          cmp_count = 0;

    fcwl_loader i_fcwl_loader (
        .mclk_i, .rst_i, .ce_i, .dev_reset_req_i, .large_part_i,
        .flash_addr_o, .flash_rd_o, .flash_data_i, .tbl_rd_i, .tbl_addr_i,
        .tbl_data_o, .dev_reset_o, .scan_port_enable_o,
        .general_code_protect_o, .general_write_protect_o, .debug_mode_o,
        .retention_regulator_cfg_o, .retention_allowed_o,
        .emulator_pin_pair_select_o, .emulator_pin_reserved_o,
        .watchdog_force_on_o, .watchdog_sw_ctl_o, .watchdog_run_only_o,
        .window_watchdog_disable_o, .window_cfg_error_o,
        .watchdog_prescale_select_o, .watchdog_postscale_select_o,
        .initial_oscillator_select_o, .primary_osc_config_o,
        .clock_switch_enable_o, .clock_monitor_enable_o
    );
    fcwl_flash_model i_fcwl_flash_model (
        .mclk_i, .ce_i, .large_part_i, .flash_rd_i(flash_rd_o),
        .flash_addr_i(flash_addr_o), .word1_i(fw[0]), .word2_i(fw[1]),
        .word3_i(fw[2]), .word4_i(fw[3]), .flash_data_o(flash_data_i)
    );

    // 25 MHz system clock
    always #20 mclk_i = ~mclk_i;

    task automatic chk(input string nm, input logic [23:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // reads start at the top word and step down by two; strobes counted
    always @(posedge mclk_i) begin
        if (dev_reset_req_i || rst_i) begin
            idx = 0;
            n_rd = 0;
        end else if (ce_i && flash_rd_o) begin
            n_rd++;
            if (addr_chk) begin
                chk("faddr", flash_addr_o, (large_part_i ? 24'h0157FE
                    : 24'h00ABFE) - 24'(2 * idx));
                idx = (idx + 1) % 4;
            end
        end
    end

    task automatic chk_dec(input logic [23:0] w1, w2);
        chk("scan", scan_port_enable_o, w1[14]);
        chk("gcp", general_code_protect_o, !w1[13]);
        chk("general_write_protect", general_write_protect_o, !w1[12]);
        chk("debug", debug_mode_o, !w1[11]);
        chk("regcfg", retention_regulator_cfg_o, w1[10]);
        chk("retention_firmware_enable", retention_allowed_o, !w1[10]);
        chk("ics", emulator_pin_pair_select_o, w1[9:8]);
        chk("icsrsv", emulator_pin_reserved_o, w1[9:8] == 2'b00);
        chk("wdon", watchdog_force_on_o, w1[7:6] == 2'b11);
        chk("wdsw", watchdog_sw_ctl_o, w1[7:6] == 2'b10);
        chk("wdrun", watchdog_run_only_o, w1[7:6] == 2'b01);
        chk("window_watchdog_disable", window_watchdog_disable_o, w1[5]);
        chk("winerr", window_cfg_error_o, !w1[5] && !w1[7] && !w1[6]);
        chk("psa", watchdog_prescale_select_o, w1[4]);
        chk("post", watchdog_postscale_select_o, w1[3:0]);
        chk("osc", initial_oscillator_select_o, w2[10:8]);
        chk("posc", primary_osc_config_o, w2[1:0]);
        chk("cksw", clock_switch_enable_o, !w2[7]);
        chk("cmon", clock_monitor_enable_o, w2[7:6] == 2'b00);
    endtask

    // bounded wait for the loader to let the device out of reset
    task automatic wait_done();
        int n;
        n = 0;
        @(negedge mclk_i);
        while (dev_reset_o !== 1'b0 && n < 200) begin
            @(negedge mclk_i);
            n++;
        end
        chk("done", dev_reset_o, 1'b0);
    endtask

    // new flash contents, then a device reset request reloads them
    task automatic load(input logic [23:0] a, b, c, d, input logic lg);
        @(posedge mclk_i);
        fw[0] <= a;
        fw[1] <= b;
        fw[2] <= c;
        fw[3] <= d;
        large_part_i <= lg;
        dev_reset_req_i <= 1'b1;
        @(posedge mclk_i);
        dev_reset_req_i <= 1'b0;
        wait_done();
        chk_dec(a, b);
        chk("nrd", 24'(n_rd), 24'h000004);
    endtask

    task automatic tbl(input logic [23:0] addr, exp);
        @(posedge mclk_i);
        tbl_rd_i <= 1'b1;
        tbl_addr_i <= addr;
        @(posedge mclk_i);
        tbl_rd_i <= 1'b0;
        #1;
        chk("tbl", tbl_data_o, exp);
    endtask

    // erased decodes in reset; flash starts cleared, so protection engages
    task automatic t_reset();
        repeat (5) @(posedge mclk_i);
        #1;
        chk_dec(24'hFFFFFF, 24'hFFFFFF);
        chk("rstdev", dev_reset_o, 1'b1);
        chk("rsttbl", tbl_data_o, 24'h000000);
        @(posedge mclk_i);
        rst_i <= 1'b0;
        wait_done();
        chk_dec(24'h000000, 24'h000000);
        chk("nrd", 24'(n_rd), 24'h000004);
    endtask

    // walk every field code, both part sizes, postscaler ends
    task automatic t_codes();
        logic [2:0]  k;
        logic [23:0] w1, w2;
        for (int i = 0; i < 8; i++) begin
            k = 3'(i);
            w1 = {8'h00, 1'b0, k[0], k[1], k[2], !k[0], k[1], k[1:0],
                  k[2:1], k[0], !k[1], k, k[0]};
            w2 = {13'h0000, k, k[1:0], 4'h0, ~k[1:0]};
            load(w1, w2, 24'h000000, 24'h00FFFF, k[0]);
        end
    endtask

    // table reads of all four words, upper byte ones, others read zero
    task automatic t_table();
        load(24'h004C3A, 24'h0007C1, 24'h0055AA, 24'h00AA55, 1'b0);
        tbl(24'hF80000, 24'hFF4C3A);
        tbl(24'hF80002, 24'hFF07C1);
        tbl(24'hF80004, 24'hFF55AA);
        tbl(24'hF80006, 24'hFFAA55);
        tbl(24'hF80008, 24'h000000);
        tbl(24'h800000, 24'h000000);
    endtask

    // reset request mid-load: old settings stand, device held, reload
    task automatic t_restart();
        load(24'h006DB5, 24'h0002C2, 24'h000001, 24'h000002, 1'b1);
        addr_chk = 1'b0;
        @(posedge mclk_i);
        fw[0] <= 24'h007FFF;
        dev_reset_req_i <= 1'b1;
        @(posedge mclk_i);
        dev_reset_req_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        #1;
        chk("midhold", dev_reset_o, 1'b1);
        chk_dec(24'h006DB5, 24'h0002C2);
        @(posedge mclk_i);
        ce_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        ce_i <= 1'b1;
        load(24'h0039C6, 24'h000640, 24'h000003, 24'h000004, 1'b0);
        addr_chk = 1'b1;
    endtask

    task automatic test_done();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        t_reset();
        t_codes();
        t_table();
        t_restart();
        test_done();
    end

    // hang guard, well beyond the few hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge mclk_i);
        n_mismatch++;
        test_done();
    end
endmodule
`default_nettype wire
